// ===== hdl/lcc_pkg.sv
package lcc_pkg;
  localparam logic [4:0] ADDR_LINE_CTRL = 5'h00;
  localparam logic [4:0] ADDR_CODING_CTRL = 5'h01;
  localparam logic [7:0] CTRL_RESET_VALUE = 8'h00;
  localparam logic [7:0] CODING_WRITE_MASK = 8'hBF;
  // Line mode and clock routing fields
  localparam int LINE_STANDARD_POS = 7;
  localparam int UNIPOLAR_POS = 6;
  localparam int LOSS_ALT_POS = 5;
  localparam int SNAPSHOT_POS = 4;
  localparam int JITTER_SRC_POS = 3;
  localparam int TX_TO_JITTER_POS = 2;
  localparam int TX_TO_RX_POS = 1;
  localparam int FALLBACK_POS = 0;
  // Coding, edge and driver fields
  localparam int ALARM_SEL_POS = 7;
  localparam int LIMIT_DIS_POS = 5;
  localparam int CUSTOM_DRV_POS = 4;
  localparam int RX_SUBST_DIS_POS = 3;
  localparam int TX_SUBST_DIS_POS = 2;
  localparam int TX_EDGE_POS = 1;
  localparam int RX_EDGE_POS = 0;
  // Carrier loss zero counts
  localparam logic [11:0] LOSS_ZEROS_E1 = 12'd255;
  localparam logic [11:0] LOSS_ZEROS_T1 = 12'd192;
  localparam logic [11:0] LOSS_ZEROS_E1_ALT = 12'd2048;
  localparam logic [11:0] LOSS_ZEROS_T1_ALT = 12'd1544;
  // Transmit clock watchdog
  localparam int CLK_PERIOD_NS = 40;
  localparam int TX_CLK_LOSS_NS = 5000;
  localparam int TX_CLK_LOSS_CYCLES = (TX_CLK_LOSS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam logic [7:0] TX_CLK_LOSS_COUNT = 8'(TX_CLK_LOSS_CYCLES);
endpackage

// ===== hdl/lcc_mon_if.sv
`timescale 1ns/1ps
interface lcc_mon_if;
  logic txClkEdge;
  logic txClkLost;
  modport monitor (output txClkEdge, output txClkLost);
  modport bank (input txClkEdge, input txClkLost);
endinterface

// ===== hdl/lcc_transmit_clock_monitor.sv
`timescale 1ns/1ps
module lcc_txclk_monitor (
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic transmitClock,
  lcc_mon_if.monitor mon
);
  logic [2:0] sync_r;
  logic level_r;
  logic [7:0] idle_r;

  // Pin is asynchronous; stage 0 feeds only stage 1
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      sync_r <= 3'h0;
    end else begin
      sync_r <= {sync_r[1:0], transmitClock};
    end
  end

  // A change counts once stages 1 and 2 agree
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      level_r <= 1'b0;
    end else if (sync_r[1] == sync_r[2]) begin
      level_r <= sync_r[2];
    end
  end

  assign mon.txClkEdge = (sync_r[1] == sync_r[2]) && (sync_r[2] != level_r);

  // Saturating idle count; lost once 5 us pass without an edge
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      idle_r <= 8'h00;
    end else if (mon.txClkEdge) begin
      idle_r <= 8'h00;
    end else if (idle_r != lcc_pkg::TX_CLK_LOSS_COUNT) begin
      idle_r <= idle_r + 8'h01;
    end
  end

  assign mon.txClkLost = (idle_r == lcc_pkg::TX_CLK_LOSS_COUNT);
endmodule // lcc_txclk_monitor

// ===== hdl/lcc_control_bank.sv
`timescale 1ns/1ps
// Summary of operation
// [RULE1] Line standard bit clear selects E1, set selects T1.
// [RULE2] Unipolar bit clear gives bipolar rails; set gives NRZ on positive rails.
// [RULE3] In NRZ mode negative receive rail pulses on violation or excess zeros.
// [RULE4] Carrier loss after 255/192 zeros, or 2048/1544 with alternate criteria.
// [RULE5] Snapshot rising edge copies error counts next cycle and clears counter.
// [RULE6] Host waits two line clocks after snapshot before reading counts.
// [RULE7] Jitter clock source: master clock when clear, internal PLL when set.
// [RULE8] Host supplies 2.048 MHz master clock, 1.544 MHz only T1 direct.
// [RULE9] Enable bits route transmit clock to jitter clock and receive clock.
// [RULE10] Fallback bit lets transmit logic switch to jitter clock on clock loss.
// [RULE11] Alarm pin shows carrier loss, or 5 us transmit clock loss when selected.
// [RULE12] Host writes zero to unassigned bit six of second register.
// [RULE13] In E1 limit-disable bit clear keeps current limiter on, set disables.
// [RULE14] Custom driver: square wave with zero build-out, else open drain.
// [RULE15] Receive substitution bit clear enables HDB3/B8ZS decoding, set disables.
// [RULE16] Transmit substitution bit clear enables HDB3/B8ZS encoding, set disables.
// [RULE17] Transmit rails sampled on falling clock edge, rising when bit set.
// [RULE18] Receive rails updated on rising clock edge, falling when bit set.
// [RULE19] Reset clears both control registers and all status to zero.
// [RULE20] Trigger edges found by comparing written value with stored bit.
module lcc_control_bank #(
  parameter int ERR_WIDTH = 16
) (
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic [4:0] regAddr,
  input wire logic regWrEn,
  input wire logic [7:0] regWrData,
  input wire logic regRdEn,
  output logic [7:0] regRdData,
  input wire logic hardwareMode,
  input wire logic transmitClock,
  input wire logic [2:0] buildOutSelect,
  input wire logic rxBitStrobe,
  input wire logic rxBitOne,
  input wire logic rxNegIn,
  input wire logic rxViolation,
  input wire logic errorEvent,
  output logic [ERR_WIDTH-1:0] errorCountSnap,
  output logic lineStandardT1,
  output logic unipolarData,
  output logic rxNegRailOut,
  output logic receiveCarrierLoss,
  output logic jitterClockFromPll,
  output logic txClockToJitterClock,
  output logic txClockToRxClock,
  output logic txUseJitterClock,
  output logic alarmPinOut,
  output logic currentLimitEnable,
  output logic lineSquareWave,
  output logic lineOpenDrain,
  output logic rxZeroSubstEnable,
  output logic txZeroSubstEnable,
  output logic txSampleRising,
  output logic rxUpdateFalling
);
  logic [7:0] lineCtrl_r;
  logic [7:0] codingCtrl_r;
  logic snapshotPending_r;
  logic [ERR_WIDTH-1:0] errCount_r;
  logic [11:0] zeroRun_r;
  logic [11:0] lossThreshold;
  logic lineWr;
  logic codingWr;
  lcc_mon_if mon ();

  lcc_txclk_monitor u_monitor (
    .core_clk(core_clk),
    .rst_n(rst_n),
    .transmitClock(transmitClock),
    .mon(mon)
  );

  assign lineWr = regWrEn && (regAddr == lcc_pkg::ADDR_LINE_CTRL);
  assign codingWr = regWrEn && (regAddr == lcc_pkg::ADDR_CODING_CTRL);

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      lineCtrl_r <= lcc_pkg::CTRL_RESET_VALUE; // RULE19
    end else if (lineWr) begin
      lineCtrl_r <= regWrData;
    end
  end

  // Unassigned bit is held at zero so a careless write cannot set it
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      codingCtrl_r <= lcc_pkg::CTRL_RESET_VALUE; // RULE19
    end else if (codingWr) begin
      codingCtrl_r <= regWrData & lcc_pkg::CODING_WRITE_MASK; // RULE12
    end
  end

  // Snapshot edge: new value one, stored value zero
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      snapshotPending_r <= 1'b0;
    end else begin
      snapshotPending_r <= lineWr && regWrData[lcc_pkg::SNAPSHOT_POS] &&
                           !lineCtrl_r[lcc_pkg::SNAPSHOT_POS]; // RULE20
    end
  end

  // An error in the snapshot cycle starts the new count, so none is lost
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      errCount_r <= '0;
    end else if (snapshotPending_r) begin
      errCount_r <= ERR_WIDTH'(errorEvent); // RULE5
    end else if (errorEvent && !(&errCount_r)) begin
      errCount_r <= errCount_r + 1'b1;
    end
  end

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      errorCountSnap <= '0;
    end else if (snapshotPending_r) begin
      errorCountSnap <= errCount_r; // RULE5
    end
  end

  always_comb begin
    case ({lineCtrl_r[lcc_pkg::LINE_STANDARD_POS], lineCtrl_r[lcc_pkg::LOSS_ALT_POS]})
      2'b00: lossThreshold = lcc_pkg::LOSS_ZEROS_E1; // RULE4
      2'b01: lossThreshold = lcc_pkg::LOSS_ZEROS_E1_ALT; // RULE4
      2'b10: lossThreshold = lcc_pkg::LOSS_ZEROS_T1; // RULE4
      default: lossThreshold = lcc_pkg::LOSS_ZEROS_T1_ALT; // RULE4
    endcase
  end

  // Run length saturates at the threshold; any one ends the loss
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      zeroRun_r <= 12'h000;
    end else if (rxBitStrobe) begin
      if (rxBitOne) begin
        zeroRun_r <= 12'h000;
      end else if (zeroRun_r < lossThreshold) begin
        zeroRun_r <= zeroRun_r + 12'h001;
      end
    end
  end

  assign receiveCarrierLoss = (zeroRun_r >= lossThreshold); // RULE4

  // Negative rail: data in bipolar mode, violation flag in NRZ mode
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      rxNegRailOut <= 1'b0;
    end else if (lineCtrl_r[lcc_pkg::UNIPOLAR_POS]) begin
      rxNegRailOut <= rxViolation || (rxBitStrobe && !rxBitOne &&
                      (zeroRun_r + 12'h001 == lossThreshold)); // RULE3
    end else begin
      rxNegRailOut <= rxNegIn; // RULE2
    end
  end

  assign lineStandardT1 = lineCtrl_r[lcc_pkg::LINE_STANDARD_POS]; // RULE1
  assign unipolarData = lineCtrl_r[lcc_pkg::UNIPOLAR_POS]; // RULE2
  assign jitterClockFromPll = lineCtrl_r[lcc_pkg::JITTER_SRC_POS]; // RULE7
  assign txClockToJitterClock = lineCtrl_r[lcc_pkg::TX_TO_JITTER_POS]; // RULE9
  assign txClockToRxClock = lineCtrl_r[lcc_pkg::TX_TO_RX_POS]; // RULE9
  assign txUseJitterClock = lineCtrl_r[lcc_pkg::FALLBACK_POS] && mon.txClkLost; // RULE10

  // Hardware mode forces the carrier-loss function onto the shared pin
  assign alarmPinOut = (codingCtrl_r[lcc_pkg::ALARM_SEL_POS] && !hardwareMode) ?
                       mon.txClkLost : receiveCarrierLoss; // RULE11

  // Limiter only exists in E1; T1 leaves it on
  assign currentLimitEnable = lineStandardT1 || !codingCtrl_r[lcc_pkg::LIMIT_DIS_POS]; // RULE13
  assign lineSquareWave = codingCtrl_r[lcc_pkg::CUSTOM_DRV_POS] &&
                          (buildOutSelect == 3'h0); // RULE14
  assign lineOpenDrain = codingCtrl_r[lcc_pkg::CUSTOM_DRV_POS] &&
                         (buildOutSelect != 3'h0); // RULE14
  assign rxZeroSubstEnable = !codingCtrl_r[lcc_pkg::RX_SUBST_DIS_POS]; // RULE15
  assign txZeroSubstEnable = !codingCtrl_r[lcc_pkg::TX_SUBST_DIS_POS]; // RULE16
  assign txSampleRising = codingCtrl_r[lcc_pkg::TX_EDGE_POS]; // RULE17
  assign rxUpdateFalling = codingCtrl_r[lcc_pkg::RX_EDGE_POS]; // RULE18

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      regRdData <= 8'h00;
    end else if (regRdEn) begin
      case (regAddr)
        lcc_pkg::ADDR_LINE_CTRL: regRdData <= lineCtrl_r;
        lcc_pkg::ADDR_CODING_CTRL: regRdData <= codingCtrl_r;
        default: regRdData <= 8'h00;
      endcase
    end
  end
endmodule // lcc_control_bank

// ===== dv/lcc_control_bank_asserts.sv
`timescale 1ns/1ps
module lcc_control_bank_asserts (
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic [4:0] regAddr,
  input wire logic regWrEn,
  input wire logic [7:0] regWrData,
  input wire logic regRdEn,
  input wire logic [7:0] regRdData,
  input wire logic [2:0] buildOutSelect,
  input wire logic rxBitStrobe,
  input wire logic rxBitOne,
  input wire logic receiveCarrierLoss,
  input wire logic lineStandardT1,
  input wire logic unipolarData,
  input wire logic currentLimitEnable,
  input wire logic lineSquareWave,
  input wire logic lineOpenDrain,
  input wire logic rxZeroSubstEnable,
  input wire logic txSampleRising,
  input wire logic rxUpdateFalling
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (!rst_n);
  sequence wrLine; regWrEn && regAddr == 5'h00; endsequence
  sequence wrCode; regWrEn && regAddr == 5'h01; endsequence
  line_std_a: assert property (wrLine |=> lineStandardT1 == $past(regWrData[7]))
    else $error("line standard not taken from write");
  unipolar_a: assert property (wrLine |=> unipolarData == $past(regWrData[6]))
    else $error("unipolar select not taken from write");
  edge_sel_a: assert property (wrCode |=> txSampleRising == $past(regWrData[1])
    && rxUpdateFalling == $past(regWrData[0])) else $error("edge selects wrong");
  rx_subst_a: assert property (wrCode |=> rxZeroSubstEnable != $past(regWrData[3]))
    else $error("receive substitution enable wrong");
  e1_limit_a: assert property (!lineStandardT1 ##0 wrCode |=>
    currentLimitEnable != $past(regWrData[5])) else $error("current limiter wrong in E1");
  square_wave_a: assert property (lineSquareWave |-> buildOutSelect == 3'h0 && !lineOpenDrain)
    else $error("square wave with build-out code");
  open_drain_a: assert property (lineOpenDrain |-> buildOutSelect != 3'h0)
    else $error("open drain without build-out code");
  spare_bit_a: assert property (regRdEn && regAddr == 5'h01 |=> !regRdData[6])
    else $error("spare bit reads back set");
  loss_clear_a: assert property (rxBitStrobe && rxBitOne |-> ##2 !receiveCarrierLoss)
    else $error("carrier loss held after a one");
endmodule // lcc_control_bank_asserts
bind lcc_control_bank lcc_control_bank_asserts lcc_control_bank_asserts_i (
  .core_clk(core_clk), .rst_n(rst_n), .regAddr(regAddr), .regWrEn(regWrEn),
  .regWrData(regWrData), .regRdEn(regRdEn), .regRdData(regRdData),
  .buildOutSelect(buildOutSelect), .rxBitStrobe(rxBitStrobe), .rxBitOne(rxBitOne),
  .receiveCarrierLoss(receiveCarrierLoss), .lineStandardT1(lineStandardT1),
  .unipolarData(unipolarData), .currentLimitEnable(currentLimitEnable),
  .lineSquareWave(lineSquareWave), .lineOpenDrain(lineOpenDrain),
  .rxZeroSubstEnable(rxZeroSubstEnable), .txSampleRising(txSampleRising),
  .rxUpdateFalling(rxUpdateFalling));

// ===== dv/lcc_host_model.sv
`timescale 1ns/1ps
module lcc_host_model (
  input wire logic core_clk,
  output logic [4:0] regAddr,
  output logic regWrEn,
  output logic [7:0] regWrData,
  output logic regRdEn,
  input wire logic [7:0] regRdData
);
  // Master clock this host supplies in kHz: 2048 suits every mode, 1544 only T1 direct
  localparam int MASTER_CLK_KHZ = 2048;
  initial begin
    regAddr = 5'h1F;
    {regWrEn, regRdEn, regWrData} = 10'h000;
  end
  // Data goes to its inverse once released so stale values never look valid
  task automatic wr(input logic [4:0] a, input logic [7:0] d);
    regAddr = a;
    regWrData = (a == 5'h01) ? (d & 8'hBF) : d;
    regWrEn = 1'b1;
    @(posedge core_clk);
    #1 regWrEn = 1'b0;
    regWrData = ~regWrData;
    @(posedge core_clk);
    #1;
  endtask
  task automatic rd(input logic [4:0] a, output logic [7:0] d);
    regAddr = a;
    regRdEn = 1'b1;
    @(posedge core_clk);
    #1 regRdEn = 1'b0;
    d = regRdData;
    // Idle cycle so a following read never re-raises the strobe in this time step
    @(posedge core_clk);
    #1;
  endtask
endmodule // lcc_host_model

// ===== dv/lcc_control_bank_test.sv
`timescale 1ns/1ps
module lcc_control_bank_test;
  logic core_clk = 1'b0, rst_n = 1'b0, hwMode = 1'b0, txClk = 1'b0, strobe = 1'b0, one = 1'b0;
  logic viol = 1'b0, errEv = 1'b0, regWrEn, regRdEn, t1, uni, neg, loss, pll, tj, tr, useJ;
  logic alarm, lim, sq, od, rxs, txs, tRise, rFall;
  logic negIn = 1'b0;
  logic [2:0] bo = 3'h0;
  logic [4:0] regAddr;
  logic [7:0] regWrData, regRdData, v;
  logic [15:0] snap;
  int error_cnt = 0, num_checks = 0, cyc = 0;
  // Unipolar bit set in every mode so the excess-zero pulse is seen too
  logic [7:0] modeTab [4] = '{8'h40, 8'hC0, 8'h60, 8'hE0};
  int zeroTab [4] = '{255, 192, 2048, 1544};
  always #20 core_clk = ~core_clk;
  lcc_control_bank lcc_control_bank_i (.core_clk(core_clk), .rst_n(rst_n), .regAddr(regAddr),
    .regWrEn(regWrEn), .regWrData(regWrData), .regRdEn(regRdEn), .regRdData(regRdData),
    .hardwareMode(hwMode), .transmitClock(txClk), .buildOutSelect(bo), .rxBitStrobe(strobe),
    .rxBitOne(one), .rxNegIn(negIn), .rxViolation(viol), .errorEvent(errEv),
    .errorCountSnap(snap), .lineStandardT1(t1), .unipolarData(uni), .rxNegRailOut(neg),
    .receiveCarrierLoss(loss), .jitterClockFromPll(pll), .txClockToJitterClock(tj),
    .txClockToRxClock(tr), .txUseJitterClock(useJ), .alarmPinOut(alarm),
    .currentLimitEnable(lim), .lineSquareWave(sq), .lineOpenDrain(od),
    .rxZeroSubstEnable(rxs), .txZeroSubstEnable(txs), .txSampleRising(tRise),
    .rxUpdateFalling(rFall));
  lcc_host_model lcc_host_model_i (.core_clk(core_clk), .regAddr(regAddr), .regWrEn(regWrEn),
    .regWrData(regWrData), .regRdEn(regRdEn), .regRdData(regRdData));
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    num_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("BAD %0t got %h want %h", $time, got, exp);
    end
  endtask
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", num_checks, error_cnt);
    if (error_cnt == 0 && num_checks > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  task automatic step(input int n);
    repeat (n) @(posedge core_clk);
    #1;
  endtask
  task automatic bits(input int n, input logic b);
    one = b;
    strobe = 1'b1;
    step(n);
    strobe = 1'b0;
  endtask
  // Whole run is a few thousand cycles; the ceiling leaves ample margin
  always @(posedge core_clk) if (++cyc == 20000) begin
    error_cnt++;
    report_and_stop();
  end
  initial begin
    step(5);
    rst_n = 1'b1;
    chk({t1, uni, pll, lim, rxs, txs, alarm, sq}, 16'h1C);
    lcc_host_model_i.rd(5'h00, v); chk(v, 16'h00);
    lcc_host_model_i.rd(5'h01, v); chk(v, 16'h00);
    lcc_host_model_i.wr(5'h00, 8'hEF);
    chk({t1, uni, pll, tj, tr}, 16'h1F);
    lcc_host_model_i.wr(5'h01, 8'h2F);
    chk({lim, rxs, txs, tRise, rFall}, 16'h13);
    lcc_host_model_i.wr(5'h00, 8'h00);
    chk({t1, lim}, 16'h0);
    negIn = 1'b1;
    step(1);
    chk(neg, 16'h1);
    negIn = 1'b0;
    step(1);
    chk(neg, 16'h0);
    lcc_host_model_i.rd(5'h01, v); chk(v, 16'h2F);
    lcc_host_model_i.rd(5'h05, v); chk(v, 16'h00);
    $display("register test done");
    lcc_host_model_i.wr(5'h01, 8'h10);
    chk({sq, od}, 16'h2);
    bo = 3'h5;
    step(1);
    chk({sq, od}, 16'h1);
    $display("driver test done");
    for (int k = 3; k > 1; k--) begin
      errEv = 1'b1;
      step(k);
      errEv = 1'b0;
      lcc_host_model_i.wr(5'h00, 8'h10);
      step(2);
      chk(snap, 16'(k));
      lcc_host_model_i.wr(5'h00, 8'h00);
    end
    $display("snapshot test done");
    for (int m = 0; m < 4; m++) begin
      lcc_host_model_i.wr(5'h00, modeTab[m]);
      bits(1, 1'b1);
      step(1);
      bits(zeroTab[m] - 1, 1'b0);
      step(1);
      chk(loss, 16'h0);
      bits(1, 1'b0);
      chk(neg, 16'h1);
      step(1);
      chk(loss, 16'h1);
      bits(1, 1'b1);
      step(1); chk(loss, 16'h0);
    end
    lcc_host_model_i.wr(5'h00, 8'h40);
    viol = 1'b1;
    step(1);
    viol = 1'b0;
    chk(neg, 16'h1);
    step(1); chk(neg, 16'h0);
    $display("receive test done");
    lcc_host_model_i.wr(5'h01, 8'h80);
    lcc_host_model_i.wr(5'h00, 8'h01);
    chk({alarm, useJ}, 16'h3);
    repeat (4) begin
      txClk = ~txClk;
      step(3);
    end
    chk({alarm, useJ}, 16'h0);
    step(130); chk(alarm, 16'h1);
    lcc_host_model_i.wr(5'h00, 8'h00);
    chk(useJ, 16'h0);
    hwMode = 1'b1;
    step(1); chk(alarm, 16'h0);
    $display("clock loss test done");
    report_and_stop();
  end
endmodule // lcc_control_bank_test
